/* rtl/sam_pkg.sv */
// Operation
// - warning output on while its active warning field is clear, off when interrupted
// - stand-alone variant puts warnings only on its three multi-function pins
// - one warning output allowed with one or two zone sets
// - two warning outputs only with one zone set, one safety zone, two warning zones
// - networked variants allow two warnings; eight-pin connector allows only one
// - per-output polarity: on while clear, or on while blocked
// - networked warning outputs may exist without any pin mapping
// - one or two sourcing alarm outputs, on all but the basic stand-alone
// - alarm one asserts on dirty window warning; safety outputs stay on
// - alarm two asserts when an internal fault forced the safety pair off
// - networked variants report warning and alarm states over the network link
// - each multi-function pin is an input or output with listed functions
// - eight-pin networked variant: two pins input only, third pin either way
// - restart/reset input restarts after switch-off and recovers from a fault
// - stand-alone variant drives one safety output pair, three multi-function pins
// - dual-channel output on one pin auto-configures a second pin alike
package sam_pkg;

	localparam int         NUM_PINS         = 3;
	localparam int         NET8_IO_PIN      = 2;
	localparam int         NUM_WARN         = 2;
	localparam int         NUM_ALARM        = 2;
	localparam logic [1:0] WARN_LIMIT_ONE   = 2'h1;
	localparam logic [1:0] WARN_LIMIT_TWO   = 2'h2;
	localparam logic [1:0] TWO_WARN_SETS    = 2'h1;
	localparam logic [1:0] TWO_WARN_SAFETY  = 2'h1;
	localparam logic [1:0] TWO_WARN_ZONES   = 2'h2;

	typedef enum logic [3:0] {
		SAM_FN_NONE     = 4'h0,
		SAM_FN_RESTART  = 4'h1,
		SAM_FN_AREA     = 4'h2,
		SAM_FN_OVERRIDE = 4'h3,
		SAM_FN_MUTE1    = 4'h4,
		SAM_FN_MUTE2    = 4'h5,
		SAM_FN_MUTE_EN  = 4'h6,
		SAM_FN_WARN1    = 4'h7,
		SAM_FN_WARN2    = 4'h8,
		SAM_FN_ALARM1   = 4'h9,
		SAM_FN_ALARM2   = 4'hA,
		SAM_FN_LAMP     = 4'hB
	} sam_func_type;

	typedef enum logic [1:0] {
		SAM_VAR_BASIC = 2'h0,
		SAM_VAR_NET8  = 2'h1,
		SAM_VAR_NET   = 2'h2
	} sam_variant_type;

	typedef sam_func_type [NUM_PINS-1:0] sam_pinmap_type;

	typedef struct packed {
		sam_func_type func;
		logic         dual;
	} sam_pin_cfg_type;

	typedef struct packed {
		sam_pin_cfg_type [NUM_PINS-1:0] pin;
		logic [1:0]                     warn_count;
		logic [NUM_WARN-1:0]            warn_pol;
		logic [NUM_ALARM-1:0]           alarm_en;
		logic [1:0]                     zone_sets;
		logic [1:0]                     safety_zones;
		logic [1:0]                     warn_zones;
	} sam_cfg_type;

	typedef struct packed {
		logic bad_variant;
		logic too_many_warn;
		logic warn_unconfigured;
		logic alarm_on_basic;
		logic output_on_input_pin;
		logic dual_conflict;
	} sam_fault_type;

	typedef struct packed {
		logic restart;
		logic area_switch;
		logic override_req;
		logic mute1;
		logic mute2;
		logic mute_en;
	} sam_ctl_type;

	typedef struct packed {
		logic [NUM_WARN-1:0]  warn;
		logic [NUM_ALARM-1:0] alarm;
	} sam_status_type;

	localparam sam_cfg_type CFG_RESET = '0;

	function automatic logic sam_is_output(input sam_func_type f);
		return (f == SAM_FN_WARN1) || (f == SAM_FN_WARN2) || (f == SAM_FN_ALARM1) ||
			(f == SAM_FN_ALARM2) || (f == SAM_FN_LAMP);
	endfunction

endpackage

/* rtl/sam_aux_mux.sv */
`timescale 1ns/100ps
module sam_aux_mux (
	input  wire logic                     clock,
	input  wire logic                     rst,
	input  wire sam_pkg::sam_variant_type variant,
	input  wire sam_pkg::sam_cfg_type     cfg_in,
	input  wire logic                     cfg_load,
	input  wire logic [1:0]               warn_field_clear,
	input  wire logic                     dirty_window_warning,
	input  wire logic                     fault_off,
	input  wire logic                     safety_request,
	input  wire logic                     muting_active,
	input  wire logic [2:0]               pin_in,
	output logic [2:0]                    pin_out,
	output logic [2:0]                    pin_oe,
	output logic [1:0]                    safety_output_pair,
	output sam_pkg::sam_ctl_type          ctl,
	output logic                          restart_pulse,
	output logic                          fault_reset_pulse,
	output sam_pkg::sam_status_type       net_status,
	output logic                          net_status_valid,
	output sam_pkg::sam_pinmap_type       pin_map,
	output logic                          cfg_error,
	output sam_pkg::sam_fault_type        cfg_fault
);

	sam_pkg::sam_cfg_type     cfg_r;
	sam_pkg::sam_variant_type variant_r;
	sam_pkg::sam_pinmap_type  map_r;
	sam_pkg::sam_pinmap_type  map_nxt;
	sam_pkg::sam_fault_type   fault_nxt;
	sam_pkg::sam_fault_type   fault_r;
	logic                     error_r;
	sam_pkg::sam_ctl_type     ctl_nxt;
	sam_pkg::sam_ctl_type     ctl_r;
	logic                     restart_prev_r;
	logic                     restart_r;
	logic                     fault_reset_r;
	logic [1:0]               warn_level;
	logic [1:0]               alarm_level;
	sam_pkg::sam_status_type  status_r;
	logic                     status_valid_r;
	logic [1:0]               safety_r;
	logic [2:0]               out_r;
	logic [2:0]               oe_r;
	logic [1:0]               warn_limit;
	logic                     two_warn_ok;
	logic                     use_warn1;
	logic                     use_warn2;
	logic                     use_alarm;

	// candidate pin map and its checks; a rejected load keeps the old map running
	always_comb begin
		int j;
		j = 0;
		map_nxt   = '0;
		fault_nxt = '0;
		use_warn1 = 1'b0;
		use_warn2 = 1'b0;
		use_alarm = 1'b0;
		for (int i = 0; i < sam_pkg::NUM_PINS; i++) begin
			map_nxt[i] = cfg_in.pin[i].func;
		end
		for (int i = 0; i < sam_pkg::NUM_PINS; i++) begin
			j = (i + 1) % sam_pkg::NUM_PINS;
			if (cfg_in.pin[i].dual && sam_pkg::sam_is_output(cfg_in.pin[i].func)) begin
				if (cfg_in.pin[j].func == sam_pkg::SAM_FN_NONE) begin
					map_nxt[j] = cfg_in.pin[i].func;
				end else if (cfg_in.pin[j].func != cfg_in.pin[i].func) begin
					fault_nxt.dual_conflict = 1'b1;
				end
			end
		end
		// each dual partner is checked again against the finished map; a pin has only one dual source, so this repeats the check above
		for (int i = 0; i < sam_pkg::NUM_PINS; i++) begin
			j = (i + 1) % sam_pkg::NUM_PINS;
			if (cfg_in.pin[i].dual && sam_pkg::sam_is_output(cfg_in.pin[i].func) &&
				map_nxt[j] != cfg_in.pin[i].func) begin
				fault_nxt.dual_conflict = 1'b1;
			end
		end
		for (int i = 0; i < sam_pkg::NUM_PINS; i++) begin
			if (map_nxt[i] == sam_pkg::SAM_FN_WARN1) begin
				use_warn1 = 1'b1;
			end
			if (map_nxt[i] == sam_pkg::SAM_FN_WARN2) begin
				use_warn2 = 1'b1;
			end
			if (map_nxt[i] == sam_pkg::SAM_FN_ALARM1 || map_nxt[i] == sam_pkg::SAM_FN_ALARM2) begin
				use_alarm = 1'b1;
			end
			if (variant == sam_pkg::SAM_VAR_NET8 && i != sam_pkg::NET8_IO_PIN &&
				sam_pkg::sam_is_output(map_nxt[i])) begin
				fault_nxt.output_on_input_pin = 1'b1;
			end
		end
		if (variant != sam_pkg::SAM_VAR_BASIC && variant != sam_pkg::SAM_VAR_NET8 &&
			variant != sam_pkg::SAM_VAR_NET) begin
			fault_nxt.bad_variant = 1'b1;
		end
		if (cfg_in.warn_count > warn_limit) begin
			fault_nxt.too_many_warn = 1'b1;
		end
		// a pin may only show a warning output that the configuration defines
		if ((use_warn1 && cfg_in.warn_count < sam_pkg::WARN_LIMIT_ONE) ||
			(use_warn2 && cfg_in.warn_count < sam_pkg::WARN_LIMIT_TWO)) begin
			fault_nxt.warn_unconfigured = 1'b1;
		end
		// on the stand-alone unit a configured warning must land on a pin
		if (variant == sam_pkg::SAM_VAR_BASIC &&
			((cfg_in.warn_count >= sam_pkg::WARN_LIMIT_ONE && !use_warn1) ||
			(cfg_in.warn_count >= sam_pkg::WARN_LIMIT_TWO && !use_warn2))) begin
			fault_nxt.warn_unconfigured = 1'b1;
		end
		if (variant == sam_pkg::SAM_VAR_BASIC && (use_alarm || (|cfg_in.alarm_en))) begin
			fault_nxt.alarm_on_basic = 1'b1;
		end
	end

	always_comb begin
		two_warn_ok = (variant != sam_pkg::SAM_VAR_NET8) &&
			(cfg_in.zone_sets == sam_pkg::TWO_WARN_SETS) &&
			(cfg_in.safety_zones == sam_pkg::TWO_WARN_SAFETY) &&
			(cfg_in.warn_zones == sam_pkg::TWO_WARN_ZONES);
		warn_limit = two_warn_ok ? sam_pkg::WARN_LIMIT_TWO : sam_pkg::WARN_LIMIT_ONE;
	end

	// configuration store
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			cfg_r     <= sam_pkg::CFG_RESET;
			variant_r <= sam_pkg::SAM_VAR_BASIC;
			map_r     <= '0;
		end else if (cfg_load && !(|fault_nxt)) begin
			cfg_r     <= cfg_in;
			variant_r <= variant;
			map_r     <= map_nxt;
		end
	end

	// load verdict: the fault vector tells which check refused the last load
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			error_r <= 1'b0;
			fault_r <= '0;
		end else if (cfg_load) begin
			error_r <= |fault_nxt;
			fault_r <= fault_nxt;
		end
	end

	// output levels, all active-high as driven onto a sourcing pin
	always_comb begin
		for (int k = 0; k < sam_pkg::NUM_WARN; k++) begin
			if (cfg_r.warn_count > k[1:0]) begin
				warn_level[k] = cfg_r.warn_pol[k] ? !warn_field_clear[k] :
					warn_field_clear[k];
			end else begin
				warn_level[k] = 1'b0;
			end
		end
		if (variant_r == sam_pkg::SAM_VAR_BASIC) begin
			alarm_level = '0;
		end else begin
			alarm_level[0] = cfg_r.alarm_en[0] && dirty_window_warning;
			alarm_level[1] = cfg_r.alarm_en[1] && fault_off;
		end
	end

	// per-pin drive; an unassigned or input pin is released and low
	for (genvar i = 0; i < sam_pkg::NUM_PINS; i++) begin : g_pin
		always_ff @(posedge clock or posedge rst) begin
			if (rst) begin
				oe_r[i]  <= 1'b0;
				out_r[i] <= 1'b0;
			end else begin
				oe_r[i] <= sam_pkg::sam_is_output(map_r[i]);
				unique case (map_r[i])
					sam_pkg::SAM_FN_WARN1:  out_r[i] <= warn_level[0];
					sam_pkg::SAM_FN_WARN2:  out_r[i] <= warn_level[1];
					sam_pkg::SAM_FN_ALARM1: out_r[i] <= alarm_level[0];
					sam_pkg::SAM_FN_ALARM2: out_r[i] <= alarm_level[1];
					sam_pkg::SAM_FN_LAMP:   out_r[i] <= muting_active;
					default:                out_r[i] <= 1'b0;
				endcase
			end
		end
	end

	// input functions gathered from every pin that carries them
	always_comb begin
		ctl_nxt = '0;
		for (int i = 0; i < sam_pkg::NUM_PINS; i++) begin
			unique case (map_r[i])
				sam_pkg::SAM_FN_RESTART:  ctl_nxt.restart      = ctl_nxt.restart | pin_in[i];
				sam_pkg::SAM_FN_AREA:     ctl_nxt.area_switch  = ctl_nxt.area_switch | pin_in[i];
				sam_pkg::SAM_FN_OVERRIDE: ctl_nxt.override_req = ctl_nxt.override_req | pin_in[i];
				sam_pkg::SAM_FN_MUTE1:    ctl_nxt.mute1        = ctl_nxt.mute1 | pin_in[i];
				sam_pkg::SAM_FN_MUTE2:    ctl_nxt.mute2        = ctl_nxt.mute2 | pin_in[i];
				sam_pkg::SAM_FN_MUTE_EN:  ctl_nxt.mute_en      = ctl_nxt.mute_en | pin_in[i];
				default:                  ctl_nxt.restart      = ctl_nxt.restart;
			endcase
		end
	end

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			ctl_r <= '0;
		end else begin
			ctl_r <= ctl_nxt;
		end
	end

	// restart/reset acts on the rising edge only, so a held button does one thing
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			restart_prev_r <= 1'b0;
			restart_r      <= 1'b0;
			fault_reset_r  <= 1'b0;
		end else begin
			restart_prev_r <= ctl_r.restart;
			restart_r      <= ctl_r.restart && !restart_prev_r && !fault_off &&
				!safety_request;
			fault_reset_r  <= ctl_r.restart && !restart_prev_r && fault_off;
		end
	end

	// the safety pair ignores warnings and alarms entirely
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			safety_r <= '0;
		end else begin
			safety_r <= {2{safety_request}};
		end
	end

	// network report is independent of any pin mapping
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			status_r       <= '0;
			status_valid_r <= 1'b0;
		end else if (variant_r == sam_pkg::SAM_VAR_BASIC) begin
			status_r       <= '0;
			status_valid_r <= 1'b0;
		end else begin
			status_r.warn  <= warn_level;
			status_r.alarm <= alarm_level;
			status_valid_r <= 1'b1;
		end
	end

	assign pin_out            = out_r;
	assign pin_oe             = oe_r;
	assign safety_output_pair = safety_r;
	assign ctl                = ctl_r;
	assign restart_pulse      = restart_r;
	assign fault_reset_pulse  = fault_reset_r;
	assign net_status         = status_r;
	assign net_status_valid   = status_valid_r;
	assign pin_map            = map_r;
	assign cfg_error          = error_r;
	assign cfg_fault          = fault_r;

endmodule // sam_aux_mux

/* tb/sam_aux_mux_checker.sv */
`timescale 1ns/100ps
module sam_aux_mux_checker (
	input wire logic                     clock,
	input wire logic                     rst,
	input wire sam_pkg::sam_variant_type variant,
	input wire sam_pkg::sam_cfg_type     cfg_in,
	input wire logic                     cfg_load,
	input wire logic                     fault_off,
	input wire logic                     safety_request,
	input wire logic [2:0]               pin_out,
	input wire logic [2:0]               pin_oe,
	input wire logic [1:0]               safety_output_pair,
	input wire sam_pkg::sam_ctl_type     ctl,
	input wire logic                     restart_pulse,
	input wire logic                     fault_reset_pulse,
	input wire sam_pkg::sam_status_type  net_status,
	input wire logic                     net_status_valid,
	input wire sam_pkg::sam_pinmap_type  pin_map,
	input wire logic                     cfg_error
);
	default clocking @(posedge clock); endclocking
	default disable iff (rst);
	property p_on; safety_request |=> safety_output_pair == 2'h3; endproperty
	property p_off; !safety_request |=> safety_output_pair == 2'h0; endproperty
	property p_oe; (pin_out & ~pin_oe) == 3'h0; endproperty
	property p_map; !cfg_load |=> $stable(pin_map); endproperty
	property p_refuse; cfg_load ##1 cfg_error |-> $stable(pin_map); endproperty
	property p_net8; cfg_load && variant == sam_pkg::SAM_VAR_NET8 && cfg_in.warn_count > 2'h1
		|=> cfg_error; endproperty
	property p_net8pin; cfg_load && variant == sam_pkg::SAM_VAR_NET8
		&& cfg_in.pin[0].func >= sam_pkg::SAM_FN_WARN1 |=> cfg_error; endproperty
	property p_dual; cfg_load && cfg_in.pin[0].dual && cfg_in.pin[0].func >= sam_pkg::SAM_FN_WARN1
		##1 !cfg_error |-> pin_map[1] == pin_map[0]; endproperty
	property p_basic; !net_status_valid |-> net_status == '0; endproperty
	property p_restart; $rose(ctl.restart) && !fault_off && !safety_request
		|=> restart_pulse ##1 !restart_pulse; endproperty
	property p_freset; $rose(ctl.restart) && fault_off
		|=> fault_reset_pulse && !restart_pulse; endproperty
	a_on: assert property (p_on) else $error("safety pair not on");
	a_off: assert property (p_off) else $error("safety pair not off");
	a_oe: assert property (p_oe) else $error("undriven pin shows data");
	a_map: assert property (p_map) else $error("pin map moved");
	a_refuse: assert property (p_refuse) else $error("refused load changed map");
	a_net8: assert property (p_net8) else $error("second warning accepted");
	a_net8pin: assert property (p_net8pin) else $error("output on input pin");
	a_dual: assert property (p_dual) else $error("dual pin not copied");
	a_basic: assert property (p_basic) else $error("status on stand-alone");
	a_restart: assert property (p_restart) else $error("restart pulse wrong");
	a_freset: assert property (p_freset) else $error("fault reset pulse wrong");
	c_restart: cover property ($rose(restart_pulse));
	c_freset: cover property ($rose(fault_reset_pulse));
	c_refuse: cover property ($rose(cfg_error));
endmodule // sam_aux_mux_checker

bind sam_aux_mux sam_aux_mux_checker i_sam_aux_mux_checker (.clock, .rst, .variant, .cfg_in,
	.cfg_load, .fault_off, .safety_request, .pin_out, .pin_oe, .safety_output_pair, .ctl,
	.restart_pulse, .fault_reset_pulse, .net_status, .net_status_valid, .pin_map, .cfg_error);

/* tb/sam_machine_side.sv */
`timescale 1ns/100ps
module sam_machine_side (
	input  wire logic       clock,
	input  wire logic       slow,
	input  wire logic [2:0] press,
	input  wire logic [2:0] pin_out,
	input  wire logic [2:0] pin_oe,
	output logic [2:0]      pin_in
);
	logic [2:0] press_r;
	// slow relay contacts close one cycle late
	always_ff @(posedge clock) press_r <= press;
	// a released line is pulled down, so an idle input reads 0
	always_comb
		for (int i = 0; i < 3; i++)
			pin_in[i] = pin_oe[i] ? pin_out[i] : (slow ? press_r[i] : press[i]);
endmodule // sam_machine_side

/* tb/tb_sam_aux_mux.sv */
`timescale 1ns/100ps
module tb_sam_aux_mux;
	logic                     clock = 1'b0, rst = 1'b1, load = 1'b0, dww = 1'b0, flt = 1'b0;
	logic                     sreq = 1'b0, mute = 1'b0, slow = 1'b0, rp, frp, nsv, cerr;
	logic [1:0]               wfc = 2'h3, pair;
	logic [2:0]               press = 3'h0, pin_in, pin_out, pin_oe;
	sam_pkg::sam_variant_type vsel = sam_pkg::SAM_VAR_NET;
	sam_pkg::sam_cfg_type     cfg = sam_pkg::CFG_RESET, c;
	sam_pkg::sam_ctl_type     ctl;
	sam_pkg::sam_status_type  ns;
	sam_pkg::sam_pinmap_type  pmap;
	sam_pkg::sam_fault_type   cf;
	int                       err_count = 0, checks_done = 0, cyc = 0;

	always #10 clock = ~clock;

	sam_aux_mux i_sam_aux_mux (.clock(clock), .rst(rst), .variant(vsel), .cfg_in(cfg),
		.cfg_load(load), .warn_field_clear(wfc), .dirty_window_warning(dww), .fault_off(flt),
		.safety_request(sreq), .muting_active(mute), .pin_in(pin_in), .pin_out(pin_out),
		.pin_oe(pin_oe), .safety_output_pair(pair), .ctl(ctl), .restart_pulse(rp),
		.fault_reset_pulse(frp), .net_status(ns), .net_status_valid(nsv), .pin_map(pmap),
		.cfg_error(cerr), .cfg_fault(cf));
	sam_machine_side i_sam_machine_side (.clock(clock), .slow(slow), .press(press),
		.pin_out(pin_out), .pin_oe(pin_oe), .pin_in(pin_in));

	task step;
		@(posedge clock);
		#2;
	endtask

	task chk(input logic [15:0] got, input logic [15:0] exp);
		checks_done++;
		if (got !== exp) begin
			err_count++;
			$display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task give_verdict;
		$display("comparisons %0d mismatches %0d", checks_done, err_count);
		if (err_count == 0 && checks_done > 0) $display("NO MISMATCHES");
		else $display("MISMATCHES SEEN");
		$finish;
	endtask

	// zone layout defaults to one set, one safety zone, two warning zones
	function automatic sam_pkg::sam_cfg_type mk(input sam_pkg::sam_func_type f0, f1, f2,
		input logic [1:0] wc, ae);
		sam_pkg::sam_cfg_type r;
		r = sam_pkg::CFG_RESET;
		r.pin[0].func = f0;
		r.pin[1].func = f1;
		r.pin[2].func = f2;
		r.warn_count = wc;
		r.alarm_en = ae;
		r.zone_sets = 2'h1;
		r.safety_zones = 2'h1;
		r.warn_zones = 2'h2;
		return r;
	endfunction

	task ld(input sam_pkg::sam_variant_type v, input sam_pkg::sam_cfg_type x, input logic e);
		vsel = v;
		cfg = x;
		load = 1'b1;
		step;
		load = 1'b0;
		step;
		chk(cerr, e);
	endtask

	task t_reset;
		chk({pin_oe, pin_out, cerr, nsv, pair}, 16'h0);
		chk(pmap, 16'h0);
		$display("test reset done");
	endtask

	task t_warn;
		c = mk(sam_pkg::SAM_FN_WARN1, sam_pkg::SAM_FN_WARN2, sam_pkg::SAM_FN_ALARM1, 2'h2, 2'h3);
		c.warn_pol = 2'h2;
		ld(sam_pkg::SAM_VAR_NET, c, 1'b0);
		chk(pin_oe, 16'h7);
		sreq = 1'b1;
		for (int i = 0; i < 4; i++) begin
			wfc = i[1:0];
			dww = i[0];
			flt = i[1];
			step;
			chk(pin_out, {dww, ~wfc[1], wfc[0]});
			chk(ns.alarm, {flt, dww});
			chk(ns.warn, {~wfc[1], wfc[0]});
			chk(pair, 16'h3);
		end
		{sreq, flt, dww} = 3'h0;
		$display("test warning and alarm done");
	endtask

	task t_reject;
		ld(sam_pkg::SAM_VAR_NET8, mk(sam_pkg::SAM_FN_NONE, sam_pkg::SAM_FN_NONE,
			sam_pkg::SAM_FN_WARN1, 2'h2, 2'h0), 1'b1);
		chk(cf, 16'h10);
		ld(sam_pkg::SAM_VAR_NET8, mk(sam_pkg::SAM_FN_WARN1, sam_pkg::SAM_FN_NONE,
			sam_pkg::SAM_FN_NONE, 2'h1, 2'h0), 1'b1);
		chk(cf, 16'h02);
		ld(sam_pkg::SAM_VAR_BASIC, mk(sam_pkg::SAM_FN_ALARM1, sam_pkg::SAM_FN_NONE,
			sam_pkg::SAM_FN_NONE, 2'h0, 2'h1), 1'b1);
		chk(cf, 16'h04);
		ld(sam_pkg::SAM_VAR_BASIC, mk(sam_pkg::SAM_FN_NONE, sam_pkg::SAM_FN_NONE,
			sam_pkg::SAM_FN_NONE, 2'h1, 2'h0), 1'b1);
		chk(cf, 16'h08);
		ld(sam_pkg::sam_variant_type'(2'h3), mk(sam_pkg::SAM_FN_NONE, sam_pkg::SAM_FN_NONE,
			sam_pkg::SAM_FN_NONE, 2'h0, 2'h0), 1'b1);
		chk(cf, 16'h20);
		c = mk(sam_pkg::SAM_FN_WARN1, sam_pkg::SAM_FN_AREA, sam_pkg::SAM_FN_NONE, 2'h1, 2'h0);
		c.pin[0].dual = 1'b1;
		ld(sam_pkg::SAM_VAR_NET, c, 1'b1);
		chk(cf, 16'h01);
		c = mk(sam_pkg::SAM_FN_WARN1, sam_pkg::SAM_FN_WARN2, sam_pkg::SAM_FN_NONE, 2'h2, 2'h0);
		c.zone_sets = 2'h2;
		ld(sam_pkg::SAM_VAR_NET, c, 1'b1);
		chk(cf, 16'h10);
		chk(pmap, 16'h987);
		c.warn_count = 2'h1;
		c.pin[1].func = sam_pkg::SAM_FN_NONE;
		ld(sam_pkg::SAM_VAR_NET, c, 1'b0);
		ld(sam_pkg::SAM_VAR_NET, mk(sam_pkg::SAM_FN_NONE, sam_pkg::SAM_FN_NONE,
			sam_pkg::SAM_FN_NONE, 2'h2, 2'h0), 1'b0);
		wfc = 2'h1;
		step;
		chk(ns.warn, 16'h1);
		ld(sam_pkg::SAM_VAR_NET8, mk(sam_pkg::SAM_FN_RESTART, sam_pkg::SAM_FN_AREA,
			sam_pkg::SAM_FN_WARN1, 2'h1, 2'h0), 1'b0);
		chk(pin_oe, 16'h4);
		$display("test refusals done");
	endtask

	task t_dual;
		c = mk(sam_pkg::SAM_FN_WARN1, sam_pkg::SAM_FN_NONE, sam_pkg::SAM_FN_LAMP, 2'h1, 2'h0);
		c.pin[0].dual = 1'b1;
		ld(sam_pkg::SAM_VAR_BASIC, c, 1'b0);
		chk(pmap, 16'hB77);
		mute = 1'b1;
		step;
		chk(pin_out, 16'h7);
		chk(nsv, 16'h0);
		mute = 1'b0;
		$display("test dual and lamp done");
	endtask

	task t_input;
		ld(sam_pkg::SAM_VAR_NET, mk(sam_pkg::SAM_FN_AREA, sam_pkg::SAM_FN_MUTE_EN,
			sam_pkg::SAM_FN_RESTART, 2'h0, 2'h0), 1'b0);
		press = 3'h7;
		step;
		chk(ctl, 16'h31);
		step;
		chk({rp, frp}, 16'h2);
		step;
		chk(rp, 16'h0);
		press = 3'h0;
		step;
		step;
		{flt, slow, press} = 5'h1C;
		step;
		step;
		chk(ctl.restart, 16'h1);
		step;
		chk({rp, frp}, 16'h1);
		{flt, slow, press} = 5'h0;
		ld(sam_pkg::SAM_VAR_NET, mk(sam_pkg::SAM_FN_OVERRIDE, sam_pkg::SAM_FN_MUTE1,
			sam_pkg::SAM_FN_MUTE2, 2'h0, 2'h0), 1'b0);
		press = 3'h7;
		step;
		chk(ctl, 16'h0E);
		press = 3'h0;
		$display("test restart inputs done");
	endtask

	// generous ceiling: the whole sequence needs well under 200 cycles
	always @(posedge clock) begin
		cyc++;
		if (cyc == 2000) begin
			err_count++;
			$display("timeout reached");
			give_verdict;
		end
	end

	initial begin
		repeat (10) @(posedge clock);
		#2 rst = 1'b0;
		t_reset;
		t_warn;
		t_reject;
		t_dual;
		t_input;
		give_verdict;
	end
endmodule // tb_sam_aux_mux
